// >>> hdl/afa_pkg.sv
package afa_pkg;
    // register bus offsets
    localparam logic [7:0] OFS_ALU_FLAGS = 8'h00;
    localparam logic [7:0] OFS_WORKING = 8'h01;
    localparam logic [7:0] OFS_BANK_POINTER = 8'h02;
    localparam logic [7:0] OFS_CONFIG = 8'h03;
    localparam logic [7:0] OFS_POINTER_LOW_BYTE0 = 8'h04;
    localparam logic [7:0] OFS_LAST = 8'h09;
    // reset values
    localparam logic [4:0] RST_FLAGS = 5'h00;
    localparam logic [7:0] RST_WORKING = 8'h00;
    localparam logic [3:0] RST_BANK = 4'h0;
    localparam logic [11:0] RST_POINTER = 12'h000;
    // flag bit positions inside alu_flags, then the extended-set bit inside config
    localparam int FLG_N = 4;
    localparam int FLG_OV = 3;
    localparam int FLG_Z = 2;
    localparam int FLG_DC = 1;
    localparam int FLG_C = 0;
    localparam int CFG_XSET = 0;
    // opcode field positions
    localparam int OPW_ACC = 8;
    localparam int OPW_DEST = 9;
    localparam int OPW_BIT_LO = 9;
    // data space map
    localparam logic [11:0] FLAGS_SFR = 12'hfd8;
    localparam logic [11:0] OPND_BASE = 12'hfef;
    localparam logic [11:0] OPND_STRIDE = 12'h008;
    localparam logic [11:0] OPND_SPAN = 12'h004;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    // operand kinds inside one pointer group, counted down from its base
    localparam logic [2:0] SEL_PLAIN = 3'h0;
    localparam logic [2:0] SEL_AUTO_INCREMENT_AFTER_OPERAND = 3'h1;
    localparam logic [2:0] SEL_AUTO_DECREMENT_AFTER_OPERAND = 3'h2;
    localparam logic [2:0] SEL_AUTO_INCREMENT_BEFORE_OPERAND = 3'h3;
    localparam logic [2:0] SEL_WORKING_OFFSET_OPERAND = 3'h4;
    localparam int NUM_PAIRS = 3;

    typedef enum logic [3:0] {
        no_op, add_working_to_file_op, add_literal_op, subtract_working_from_file_op,
        subtract_from_literal_op, and_working_op, clear_file_op, working_to_file_move_op,
        file_to_file_move_op, bit_clear_op, bit_set_op, nibble_swap_op,
        rotate_left_op, rotate_right_op, call_jump_op
    } afa_op_t;

    typedef enum logic [1:0] {st_idle, st_read, st_exec} afa_state_t;
endpackage

// >>> hdl/afa_ptr_pair.sv
`timescale 1ns/1ps
module afa_ptr_pair (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [7:0] wdata,
    input wire logic step_inc,
    input wire logic step_dec,
    output logic [11:0] ptr
);
    import afa_pkg::*;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ptr <= RST_POINTER;
        end else if (clk_en) begin
            if (wr_lo) begin
                ptr[7:0] <= wdata;
            end else if (wr_hi) begin
                ptr[11:8] <= wdata[3:0];
            end else if (step_inc) begin
                ptr <= ptr + 12'h001;
            end else if (step_dec) begin
                ptr <= ptr - 12'h001;
            end
        end
    end
endmodule

// >>> hdl/afa_flag_calc.sv
`timescale 1ns/1ps
module afa_flag_calc (
    input afa_pkg::afa_op_t kind,
    input wire logic [7:0] opnd,
    input wire logic [7:0] w,
    input wire logic [7:0] lit,
    input wire logic [2:0] bitsel,
    input wire logic [4:0] flags_in,
    output logic [7:0] res,
    output logic [4:0] fmask,
    output logic [4:0] fval
);
    import afa_pkg::*;

    logic [7:0] x;
    logic [7:0] y;
    logic cin;
    logic use_add;
    logic [4:0] lo5;
    logic [8:0] s9;

    always_comb begin
        x = opnd;
        y = w;
        cin = 1'b0;
        use_add = 1'b0;
        res = opnd;
        fmask = 5'h00;
        fval = flags_in;
        case (kind)
            add_working_to_file_op: begin
                use_add = 1'b1;
            end
            add_literal_op: begin
                x = lit;
                use_add = 1'b1;
            end
            subtract_working_from_file_op: begin
                y = ~w;
                cin = 1'b1;
                use_add = 1'b1;
            end
            subtract_from_literal_op: begin
                x = lit;
                y = ~w;
                cin = 1'b1;
                use_add = 1'b1;
            end
            and_working_op: begin
                res = opnd & w;
                fmask = 5'h14;
            end
            clear_file_op: begin
                res = 8'h00;
                fmask = 5'h04;
            end
            // moves and bit ops keep flags
            working_to_file_move_op: res = w;
            file_to_file_move_op: res = opnd;
            bit_clear_op: res = opnd & ~(8'h01 << bitsel);
            bit_set_op: res = opnd | (8'h01 << bitsel);
            nibble_swap_op: res = {opnd[3:0], opnd[7:4]};
            // rotate loads carry and nibble carry from source
            rotate_left_op: begin
                res = {opnd[6:0], flags_in[FLG_C]};
                fmask = 5'h17;
                fval[FLG_C] = opnd[7];
                fval[FLG_DC] = opnd[3];
            end
            rotate_right_op: begin
                res = {flags_in[FLG_C], opnd[7:1]};
                fmask = 5'h17;
                fval[FLG_C] = opnd[0];
                fval[FLG_DC] = opnd[4];
            end
            default: res = opnd;
        endcase
        lo5 = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
        s9 = {1'b0, x} + {1'b0, y} + {8'h00, cin};
        if (use_add) begin
            res = s9[7:0];
            fmask = 5'h1f;
            // carry out of the top bit
            fval[FLG_C] = s9[8];
            // carry out of the low nibble
            fval[FLG_DC] = lo5[4];
            fval[FLG_OV] = (x[7] == y[7]) && (s9[7] != x[7]);
        end
        if (fmask[FLG_N]) begin
            fval[FLG_N] = res[7];
        end
        if (fmask[FLG_Z]) begin
            fval[FLG_Z] = (res == 8'h00);
        end
    end
endmodule

// >>> hdl/afa_core.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module afa_core (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic op_go,
    input afa_pkg::afa_op_t op_kind,
    input wire logic [15:0] op_word,
    input wire logic [15:0] op_ext,
    output logic op_busy,
    output logic op_done,
    output logic jump_valid,
    output logic [19:0] jump_target,
    output logic [11:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata
);
    import afa_pkg::*;

    afa_state_t state_r;
    afa_op_t kind_r;
    logic [15:0] word_r;
    logic [15:0] ext_r;
    logic [11:0] addr_r;
    logic hit_r;
    logic [1:0] pair_r;
    logic [2:0] sel_r;
    logic [4:0] flags_r;
    logic [7:0] w_r;
    logic [3:0] bank_r;
    logic xset_r;
    logic [11:0] ptr_val [NUM_PAIRS];
    logic [NUM_PAIRS-1:0] hit_v;
    logic [2:0] sel_v [NUM_PAIRS];
    logic [NUM_PAIRS-1:0] step_inc;
    logic [NUM_PAIRS-1:0] step_dec;
    logic [7:0] f_lit;
    logic [11:0] dir_addr;
    logic [11:0] ind_addr;
    logic [11:0] eff_addr;
    logic [1:0] pair_v;
    logic [7:0] opnd;
    logic [7:0] res;
    logic [4:0] fmask;
    logic [4:0] fval;
    logic to_file;
    logic [11:0] tgt_addr;
    logic take;
    logic exec;
    logic lit_kind;

    assign take = clk_en && op_go && (state_r == st_idle);
    assign exec = clk_en && (state_r == st_exec);
    // inherent and literal kinds never touch data memory or pointers
    assign lit_kind = (op_kind == add_literal_op) || (op_kind == subtract_from_literal_op) ||
        (op_kind == call_jump_op) || (op_kind == no_op);
    // file address from opcode low byte
    assign f_lit = op_word[7:0];

    always_comb begin
        // full source address, bank pointer unused
        if (op_kind == file_to_file_move_op) begin
            dir_addr = op_word[11:0];
        // bank pointer joins the opcode address
        end else if (op_word[OPW_ACC]) begin
            dir_addr = {bank_r, f_lit};
        end else if (f_lit < ACCESS_SPLIT) begin
            // indexed literal offset only with the extended set
            dir_addr = xset_r ? (ptr_val[2] + {4'h0, f_lit}) : {ACCESS_LO_BANK, f_lit};
        end else begin
            dir_addr = {ACCESS_HI_BANK, f_lit};
        end
    end

    genvar n;
    generate
        for (n = 0; n < NUM_PAIRS; n++) begin : g_pair
            localparam logic [11:0] BASE = OPND_BASE - 12'(n) * OPND_STRIDE;
            assign hit_v[n] = (dir_addr <= BASE) && (dir_addr >= BASE - OPND_SPAN);
            assign sel_v[n] = 3'(BASE - dir_addr);
            // post and pre steps happen in the execute cycle
            assign step_inc[n] = exec && hit_r && (pair_r == 2'(n)) &&
                ((sel_r == SEL_AUTO_INCREMENT_AFTER_OPERAND) || (sel_r == SEL_AUTO_INCREMENT_BEFORE_OPERAND));
            assign step_dec[n] = exec && hit_r && (pair_r == 2'(n)) && (sel_r == SEL_AUTO_DECREMENT_AFTER_OPERAND);
            afa_ptr_pair u_pair (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .clk_en(clk_en),
                .wr_lo(reg_wr && (reg_addr == OFS_POINTER_LOW_BYTE0 + 8'(2 * n))),
                .wr_hi(reg_wr && (reg_addr == OFS_POINTER_LOW_BYTE0 + 8'(2 * n + 1))),
                .wdata(reg_wdata),
                .step_inc(step_inc[n]),
                .step_dec(step_dec[n]),
                .ptr(ptr_val[n])
            );
        end
    endgenerate

    always_comb begin
        pair_v = hit_v[0] ? 2'd0 : (hit_v[1] ? 2'd1 : 2'd2);
        // pointer value, plus one for pre-increment or the signed working value for the offset kind, selects the target
        case (sel_v[pair_v])
            SEL_AUTO_INCREMENT_BEFORE_OPERAND: ind_addr = ptr_val[pair_v] + 12'h001;
            SEL_WORKING_OFFSET_OPERAND: ind_addr = ptr_val[pair_v] + {{4{w_r[7]}}, w_r};
            default: ind_addr = ptr_val[pair_v];
        endcase
        // pointer operand redirects to data memory
        eff_addr = (op_kind != file_to_file_move_op && |hit_v) ? ind_addr : dir_addr;
    end

    assign opnd = (addr_r == FLAGS_SFR) ? {3'h0, flags_r} : mem_rdata;

    afa_flag_calc u_calc (
        .kind(kind_r),
        .opnd(opnd),
        .w(w_r),
        .lit(word_r[7:0]),
        .bitsel(word_r[OPW_BIT_LO+2:OPW_BIT_LO]),
        .flags_in(flags_r),
        .res(res),
        .fmask(fmask),
        .fval(fval)
    );

    always_comb begin
        // dest bit picks file or working
        case (kind_r)
            add_working_to_file_op, subtract_working_from_file_op, and_working_op,
            nibble_swap_op, rotate_left_op, rotate_right_op: to_file = word_r[OPW_DEST];
            clear_file_op, working_to_file_move_op, bit_clear_op, bit_set_op,
            file_to_file_move_op: to_file = 1'b1;
            default: to_file = 1'b0;
        endcase
        tgt_addr = (kind_r == file_to_file_move_op) ? ext_r[11:0] : addr_r;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= st_idle;
            op_busy <= 1'b0;
            op_done <= 1'b0;
        end else if (clk_en) begin
            op_done <= 1'b0;
            case (state_r)
                st_idle: begin
                    if (op_go) begin
                        state_r <= st_read;
                        op_busy <= 1'b1;
                    end
                end
                st_read: state_r <= st_exec;
                st_exec: begin
                    state_r <= st_idle;
                    op_busy <= 1'b0;
                    op_done <= 1'b1;
                end
                default: state_r <= st_idle;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            kind_r <= no_op;
            word_r <= 16'h0000;
            ext_r <= 16'h0000;
            addr_r <= 12'h000;
            hit_r <= 1'b0;
            pair_r <= 2'd0;
            sel_r <= SEL_PLAIN;
        end else if (take) begin
            kind_r <= op_kind;
            word_r <= op_word;
            ext_r <= op_ext;
            addr_r <= eff_addr;
            hit_r <= (op_kind != file_to_file_move_op) && !lit_kind && (|hit_v);
            pair_r <= pair_v;
            sel_r <= sel_v[pair_v];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mem_addr <= 12'h000;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= 8'h00;
        end else if (clk_en) begin
            mem_rd <= take && !lit_kind;
            // flags target is never written to memory
            mem_wr <= exec && to_file && (tgt_addr != FLAGS_SFR);
            if (take) begin
                mem_addr <= eff_addr;
            end else if (exec) begin
                mem_addr <= tgt_addr;
                mem_wdata <= res;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            jump_valid <= 1'b0;
            jump_target <= 20'h00000;
        end else if (clk_en) begin
            jump_valid <= exec && (kind_r == call_jump_op);
            // 20-bit target from both opcode words
            if (exec && (kind_r == call_jump_op)) begin
                jump_target <= {ext_r[11:0], word_r[7:0]};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flags_r <= RST_FLAGS;
        end else if (clk_en) begin
            if (exec) begin
                // flag-affecting ops ignore their result here
                if (to_file && (tgt_addr == FLAGS_SFR) && (fmask == 5'h00)) begin
                    flags_r <= res[4:0];
                end else begin
                    flags_r <= fval;
                end
            end else if (reg_wr && (reg_addr == OFS_ALU_FLAGS)) begin
                flags_r <= reg_wdata[4:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            w_r <= RST_WORKING;
        end else if (clk_en) begin
            if (exec && !to_file && (kind_r != call_jump_op) && (kind_r != no_op)) begin
                w_r <= res;
            end else if (reg_wr && (reg_addr == OFS_WORKING)) begin
                w_r <= reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bank_r <= RST_BANK;
            xset_r <= 1'b0;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == OFS_BANK_POINTER) begin
                bank_r <= reg_wdata[3:0];
            end
            if (reg_addr == OFS_CONFIG) begin
                xset_r <= reg_wdata[CFG_XSET];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    OFS_ALU_FLAGS: reg_rdata <= {3'h0, flags_r};
                    OFS_WORKING: reg_rdata <= w_r;
                    OFS_BANK_POINTER: reg_rdata <= {4'h0, bank_r};
                    OFS_CONFIG: reg_rdata <= {7'h00, xset_r};
                    OFS_POINTER_LOW_BYTE0: reg_rdata <= ptr_val[0][7:0];
                    OFS_POINTER_LOW_BYTE0 + 8'h01: reg_rdata <= {4'h0, ptr_val[0][11:8]};
                    OFS_POINTER_LOW_BYTE0 + 8'h02: reg_rdata <= ptr_val[1][7:0];
                    OFS_POINTER_LOW_BYTE0 + 8'h03: reg_rdata <= {4'h0, ptr_val[1][11:8]};
                    OFS_POINTER_LOW_BYTE0 + 8'h04: reg_rdata <= ptr_val[2][7:0];
                    OFS_POINTER_LOW_BYTE0 + 8'h05: reg_rdata <= {4'h0, ptr_val[2][11:8]};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_unmapped_read: assert property (reg_rd && clk_en && reg_addr > OFS_LAST |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_flags_dest_nowr: assert property (
        exec && to_file && tgt_addr == FLAGS_SFR |=> !mem_wr)
        else $error("flags destination written to memory");
    a_clear_flags_zero: assert property (
        exec && kind_r == clear_file_op && tgt_addr == FLAGS_SFR
        |=> flags_r == ($past(flags_r) | 5'h04))
        else $error("clear of flags wrong pattern");
    a_move_keeps_flags: assert property (
        exec && (kind_r == working_to_file_move_op || kind_r == bit_set_op ||
        kind_r == nibble_swap_op) && tgt_addr != FLAGS_SFR |=> $stable(flags_r))
        else $error("move changed flags");
    a_sub_borrow: assert property (
        exec && kind_r == subtract_working_from_file_op && addr_r != FLAGS_SFR
        |=> flags_r[FLG_C] == ($past(mem_rdata) >= $past(w_r)))
        else $error("subtract carry is not inverted borrow");
    a_add_carry_zero: assert property (
        exec && kind_r == add_working_to_file_op && addr_r != FLAGS_SFR
        |=> flags_r[FLG_C] == (9'($past(mem_rdata)) + 9'($past(w_r)) > 9'h0ff)
        && flags_r[FLG_Z] == ($past(mem_rdata) + $past(w_r) == 8'h00))
        else $error("add carry or zero wrong");
    a_bank_address: assert property (
        take && op_kind == add_working_to_file_op && op_word[OPW_ACC] && !(|hit_v)
        |=> mem_rd && mem_addr == {$past(bank_r), $past(op_word[7:0])})
        else $error("banked address wrong");
    a_ext_gate: assert property (
        take && !xset_r && !op_word[OPW_ACC] && op_word[7:0] < ACCESS_SPLIT
        && op_kind != file_to_file_move_op |=> mem_addr[11:8] == ACCESS_LO_BANK)
        else $error("indexed mode without extended set");
    a_auto_increment_after_operand_step: assert property (
        exec && hit_r && pair_r == 2'd0 && sel_r == SEL_AUTO_INCREMENT_AFTER_OPERAND && !reg_wr
        |=> ptr_val[0] == $past(ptr_val[0]) + 12'h001)
        else $error("pointer post increment wrong");
    a_done_timing: assert property (take ##1 clk_en ##1 clk_en |=> op_done)
        else $error("done not three cycles after take");

    c_indirect: cover property (exec && hit_r && sel_r == SEL_WORKING_OFFSET_OPERAND);
    c_flags_dest: cover property (exec && to_file && tgt_addr == FLAGS_SFR);
    c_jump: cover property (jump_valid);
    c_indexed: cover property (take && xset_r && !op_word[OPW_ACC] && f_lit < ACCESS_SPLIT);
endmodule

// >>> tb/afa_mem_model.sv
`timescale 1ns/1ps
module afa_mem_model (
    input wire logic core_clk,
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] ram [0:4095];
    initial begin
        mem_rdata = 8'h00;
    end
    // read data stands one cycle after the strobe; outside it the bus toggles
    always @(posedge core_clk) begin
        if (mem_rd) begin
            mem_rdata <= ram[mem_addr];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        if (mem_wr) begin
            ram[mem_addr] <= mem_wdata;
        end
    end
endmodule

// >>> tb/tb_alu_flags_and_data_addressing.sv
`timescale 1ns/1ps
module tb_alu_flags_and_data_addressing;
    import afa_pkg::*;
    typedef struct packed {
        afa_op_t k;
        logic [15:0] w16;
        logic [7:0] wr, m;
        logic [4:0] fin;
        logic [1:0] mode;
        logic [7:0] res;
        logic [4:0] fx;
    } afa_row_t;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic op_go = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    afa_op_t op_kind = no_op;
    logic [15:0] op_word = 16'h0000;
    logic [15:0] op_ext = 16'h0000;
    logic [7:0] reg_rdata, mem_rdata, mem_wdata, rv, done_d;
    logic op_busy, op_done, jump_valid, mem_rd, mem_wr, done_wr, jv;
    logic [19:0] jump_target;
    logic [11:0] mem_addr, done_a, ea;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    afa_row_t r;
    // mode: 0 result to memory, 1 result to working, 2 flags target
    afa_row_t rows [20] = '{
        '{add_working_to_file_op, 16'h0220, 8'h08, 8'h08, 5'h00, 0, 8'h10, 5'h02},
        '{bit_clear_op, 16'h0e20, 8'h00, 8'hff, 5'h1f, 0, 8'h7f, 5'h1f},
        '{and_working_op, 16'h0220, 8'h0f, 8'hf0, 5'h1b, 0, 8'h00, 5'h0f},
        '{add_working_to_file_op, 16'h0220, 8'h80, 8'h80, 5'h00, 0, 8'h00, 5'h0d},
        '{add_working_to_file_op, 16'h0220, 8'h7f, 8'h01, 5'h00, 0, 8'h80, 5'h1a},
        '{subtract_working_from_file_op, 16'h0220, 8'h05, 8'h05, 5'h00, 0, 8'h00, 5'h07},
        '{subtract_working_from_file_op, 16'h0220, 8'h01, 8'h00, 5'h00, 0, 8'hff, 5'h10},
        '{add_literal_op, 16'h0001, 8'h0f, 8'h00, 5'h00, 1, 8'h10, 5'h02},
        '{subtract_from_literal_op, 16'h0010, 8'h01, 8'h00, 5'h00, 1, 8'h0f, 5'h01},
        '{rotate_left_op, 16'h0220, 8'h00, 8'h88, 5'h01, 0, 8'h11, 5'h03},
        '{rotate_right_op, 16'h0220, 8'h00, 8'h11, 5'h00, 0, 8'h08, 5'h03},
        '{clear_file_op, 16'h02d8, 8'h00, 8'h00, 5'h1b, 2, 8'h00, 5'h1f},
        '{clear_file_op, 16'h0220, 8'h00, 8'h55, 5'h00, 0, 8'h00, 5'h04},
        '{bit_set_op, 16'h08d8, 8'h00, 8'h00, 5'h00, 2, 8'h00, 5'h10},
        '{nibble_swap_op, 16'h0220, 8'h00, 8'h3c, 5'h15, 0, 8'hc3, 5'h15},
        '{add_working_to_file_op, 16'h02d8, 8'h01, 8'h00, 5'h01, 2, 8'h00, 5'h00},
        '{add_working_to_file_op, 16'h0020, 8'h01, 8'h02, 5'h00, 1, 8'h03, 5'h00},
        '{working_to_file_move_op, 16'h0220, 8'ha5, 8'h00, 5'h1f, 0, 8'ha5, 5'h1f},
        '{add_working_to_file_op, 16'h0344, 8'h01, 8'h01, 5'h00, 0, 8'h02, 5'h00},
        '{add_working_to_file_op, 16'h0270, 8'h01, 8'h01, 5'h00, 0, 8'h02, 5'h00}
    };
    logic [7:0] pf [5] = '{8'hee, 8'hef, 8'hed, 8'hec, 8'heb};
    logic [11:0] pa [5] = '{12'h1ff, 12'h200, 12'h200, 12'h200, 12'h1ff};

    afa_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .op_go(op_go), .op_kind(op_kind), .op_word(op_word),
        .op_ext(op_ext), .op_busy(op_busy), .op_done(op_done), .jump_valid(jump_valid),
        .jump_target(jump_target), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    afa_mem_model mem (.core_clk(core_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    always #25 core_clk = ~core_clk;

    task report_and_stop;
        if (err_total == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            report_and_stop;
        end
    end
    task chk(input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    // issue one instruction and capture the memory port in its done cycle
    task run(input afa_op_t k, input logic [15:0] w16, input logic [15:0] e16);
        @(posedge core_clk);
        op_go <= 1'b1;
        op_kind <= k;
        op_word <= w16;
        op_ext <= e16;
        @(posedge core_clk);
        op_go <= 1'b0;
        #1;
        chk(op_busy, 1'b1);
        chk(mem_rd, (k != add_literal_op) && (k != subtract_from_literal_op) &&
            (k != call_jump_op));
        for (int i = 0; i < 8 && op_done !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        chk(op_done, 1'b1);
        chk(op_busy, 1'b0);
        done_wr = mem_wr;
        done_d = mem_wdata;
        done_a = mem_addr;
        jv = jump_valid;
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int a = 0; a <= 10; a++) begin
            rd(a[7:0]);
            chk(rv, 8'h00);
        end
        @(posedge core_clk);
        #1;
        chk(reg_rdata, 8'h00);
        wr(OFS_ALU_FLAGS, 8'hff);
        rd(OFS_ALU_FLAGS);
        chk(rv, 8'h1f);
        wr(OFS_BANK_POINTER, 8'h03);
        foreach (rows[i]) begin
            r = rows[i];
            ea = r.w16[8] ? {4'h3, r.w16[7:0]} : {(r.w16[7:0] < ACCESS_SPLIT) ?
                ACCESS_LO_BANK : ACCESS_HI_BANK, r.w16[7:0]};
            wr(OFS_ALU_FLAGS, {3'h0, r.fin});
            wr(OFS_WORKING, r.wr);
            mem.ram[ea] = r.m;
            run(r.k, r.w16, 16'h0000);
            chk(done_wr, r.mode == 2'd0);
            if (r.mode == 2'd0) begin
                chk(done_d, r.res);
                chk(done_a, ea);
            end
            if (r.mode == 2'd1) begin
                rd(OFS_WORKING);
                chk(rv, r.res);
            end
            rd(OFS_ALU_FLAGS);
            chk(rv, {3'h0, r.fx});
        end
        wr(OFS_POINTER_LOW_BYTE0, 8'hff);
        wr(8'h05, 8'h01);
        wr(OFS_WORKING, 8'hff);
        wr(OFS_ALU_FLAGS, 8'h15);
        foreach (pf[i]) begin
            run(working_to_file_move_op, {8'h00, pf[i]}, 16'h0000);
            chk(done_a, pa[i]);
        end
        rd(OFS_POINTER_LOW_BYTE0);
        chk(rv, 8'h00);
        rd(8'h05);
        chk(rv, 8'h02);
        rd(OFS_ALU_FLAGS);
        chk(rv, 8'h15);
        wr(8'h06, 8'hab);
        wr(8'h08, 8'h45);
        wr(8'h09, 8'h03);
        run(working_to_file_move_op, 16'h00e7, 16'h0000);
        chk(done_a, 12'h0ab);
        run(working_to_file_move_op, 16'h00df, 16'h0000);
        chk(done_a, 12'h345);
        wr(OFS_CONFIG, 8'h01);
        run(working_to_file_move_op, 16'h0010, 16'h0000);
        chk(done_a, 12'h355);
        wr(OFS_CONFIG, 8'h00);
        run(working_to_file_move_op, 16'h0010, 16'h0000);
        chk(done_a, 12'h010);
        mem.ram[12'h123] = 8'h5a;
        run(file_to_file_move_op, 16'h0123, 16'h0456);
        chk(done_a, 12'h456);
        chk(done_d, 8'h5a);
        run(call_jump_op, 16'h0034, 16'h0abc);
        chk(jv, 1'b1);
        chk(jump_target, 20'habc34);
        clk_en <= 1'b0;
        wr(OFS_WORKING, 8'h3c);
        clk_en <= 1'b1;
        rd(OFS_WORKING);
        chk(rv, 8'hff);
        sys_rst <= 1'b1;
        @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(OFS_WORKING);
        chk(rv, 8'h00);
        rd(OFS_ALU_FLAGS);
        chk(rv, 8'h00);
        report_and_stop;
    end
endmodule
